// ==== rtl/irc_consts.svh ====
// Purpose: Offsets, field positions, reset values and codes of the receive filter
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH

// Register map, byte addresses
`define IRC_MATCH_BASE     16'h410C
`define IRC_CTRL_BASE      16'h4100
`define IRC_CTX_STRIDE     16'h0020
`define IRC_NUM_CTX        4

// Filter register fields
`define IRC_TAG_HI         31
`define IRC_TAG_LO         28
`define IRC_RSVD_HI_BIT    27
`define IRC_START_HI       26
`define IRC_START_LO       12
`define IRC_SYNC_HI        11
`define IRC_SYNC_LO        8
`define IRC_RSVD_LO_BIT    7
`define IRC_SYNC_RESTRICT  6
`define IRC_CHAN_HI        5
`define IRC_CHAN_LO        0
`define IRC_MATCH_WMASK    32'hF7FF_FF7F
`define IRC_MATCH_RESET    32'h0000_0000

// Context control fields
`define IRC_CTRL_CYCLE_EN  29
`define IRC_CTRL_RUN       15
`define IRC_CTRL_ACTIVE    10
`define IRC_CTRL_WAITING   9

// Descriptor wait and packet codes
`define IRC_WAIT_SYNC      2'h3
`define IRC_TAG_ONE        2'h1
`define IRC_SYNC_TOP_CLEAR 2'h0

// Buffered word layout: mask, channel, tag, sync
`define IRC_WORD_W         16

`endif

// ==== rtl/irc_pkg.sv ====
// Purpose: Types shared by the receive filter files
// Assumes: Constants come from irc_consts.svh
// Notes:   Types only
package irc_pkg;

  // Start-of-reception sequencing per context
  typedef enum logic [1:0] {
    IRC_IDLE       = 2'b00,
    IRC_WAIT_CYCLE = 2'b01,
    IRC_RECEIVE    = 2'b10
  } irc_ctx_state_t;

endpackage

// ==== rtl/irc_filter.sv ====
// Purpose: Acceptance decision of one receive context for one packet
// Assumes: All inputs stable in the cycle the packet is offered
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "irc_consts.svh"

module irc_filter (
  input  wire logic [3:0] accept_tags,
  input  wire logic       one_tag_sync_restrict,
  input  wire logic [5:0] accepted_channel,
  input  wire logic [3:0] sync_value,
  input  wire logic       sync_wait,
  input  wire logic       receiving,
  input  wire logic [5:0] pkt_channel,
  input  wire logic [1:0] pkt_tag,
  input  wire logic [3:0] pkt_sync,
  output logic            accept
);
  logic tag_ok;
  logic restrict_ok;
  logic sync_ok;
  logic chan_ok;

  // Individual conditions
  always_comb begin
    tag_ok      = accept_tags[pkt_tag];
    restrict_ok = 1'b1;
    if (one_tag_sync_restrict && (pkt_tag == `IRC_TAG_ONE)) begin
      restrict_ok = (pkt_sync[3:2] == `IRC_SYNC_TOP_CLEAR);
    end
    sync_ok = !sync_wait || (pkt_sync == sync_value);
    chan_ok = (pkt_channel == accepted_channel);
    accept  = receiving && tag_ok && restrict_ok && sync_ok && chan_ok;
  end
endmodule

// ==== rtl/irc_skid.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   All outputs come straight from flip-flops
`timescale 1ns/1ps

module irc_skid #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic             skid_valid_q;
  logic [WIDTH-1:0] skid_data_q;
  logic             push;
  logic             pop;

  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  // Front entry feeds the consumer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (!out_valid || pop) begin
      if (skid_valid_q) begin
        out_valid <= 1'b1;
        out_data  <= skid_data_q;
      end else begin
        out_valid <= push;
        if (push) begin
          out_data <= in_data;
        end
      end
    end
  end

  // Second entry catches a word during a stall
  always_ff @(posedge core_clk) begin
    if (reset) begin
      skid_valid_q <= 1'b0;
      skid_data_q  <= '0;
      in_ready     <= 1'b0;
    end else begin
      if (skid_valid_q && (!out_valid || pop)) begin
        skid_valid_q <= 1'b0;
        in_ready     <= 1'b1;
      end else if (push && out_valid && !pop) begin
        skid_valid_q <= 1'b1;
        skid_data_q  <= in_data;
        in_ready     <= 1'b0;
      end else begin
        in_ready <= !skid_valid_q;
      end
    end
  end
endmodule

// ==== rtl/irc_match.sv ====
// Purpose: Isochronous receive acceptance filter for four receive contexts
// Assumes: Packet headers offered with valid/ready; cycle timer fields are live
// Notes:   Registers on an Avalon-MM slave with waitrequest, one wait state
//
// Contract
// - Bits 31..28 enable tags 11b, 10b, 01b, 00b per context.
// - Filter register bits 27 and 7 always read zero.
// - Bits 26..12 hold two seconds bits and the 13-bit cycle count.
// - With cycle start enabled, reception begins when timer equals start value.
// - Sync field compared with packet sync while descriptor wait is 11b.
// - Restrict bit plus tag 01b enable: accept only sync top bits 00b.
// - The sync restriction leaves packets of other tags untouched.
// - Accept only packets whose channel equals the 6-bit channel field.
// - Four contexts, filter registers spaced 32 bytes apart.
// - Run bit is set and cleared by software; hardware only resets it.
`timescale 1ns/1ps
`include "irc_consts.svh"

module irc_match (
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Avalon-MM register slave
  input  wire logic [15:0] avs_address,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Bus cycle timer
  input  wire logic [1:0]  timer_seconds_field,
  input  wire logic [12:0] timer_cycle_field,
  // Wait field of each context's active descriptor, two bits per context
  input  wire logic [7:0]  descriptor_wait_field,
  // Incoming packet headers from the link
  input  wire logic        pkt_valid,
  output logic             pkt_ready,
  input  wire logic [5:0]  pkt_channel,
  input  wire logic [1:0]  pkt_tag,
  input  wire logic [3:0]  pkt_sync,
  // Accepted packets toward the DMA side
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [3:0]       out_context_mask,
  output logic [5:0]       out_channel,
  output logic [1:0]       out_tag,
  output logic [3:0]       out_sync
);

  localparam int NCTX = `IRC_NUM_CTX;

  // Address decode against a per-context register bank
  function automatic logic [2:0] irc_decode(input logic [15:0] addr,
                                            input logic [15:0] base);
    logic [15:0] off;
    logic [2:0]  res;
    res = 3'h0;
    off = addr - base;
    if ((addr >= base) && (off[4:0] == 5'h00) && (off[15:5] < 11'(NCTX))) begin
      res = {1'b1, off[6:5]};
    end
    return res;
  endfunction

  // Byte-lane merge with a mask of writable bits
  function automatic logic [31:0] irc_merge(input logic [31:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be,
                                            input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~lanes) | (wdata & lanes);
  endfunction

  // Register state
  logic [31:0] match_q [NCTX];
  logic [NCTX-1:0] run_q;
  logic [NCTX-1:0] cycle_en_q;
  irc_pkg::irc_ctx_state_t state_q [NCTX];
  logic [NCTX-1:0] accept;
  logic [NCTX-1:0] active;
  logic [NCTX-1:0] waiting;
  logic [14:0]     timer_now;

  // Bus handshake
  logic        req;
  logic        take;
  logic [2:0]  match_hit;
  logic [2:0]  ctrl_hit;
  logic [31:0] ctrl_word;
  logic [31:0] match_word;
  logic [31:0] rd_d;

  // Buffer wiring
  logic                     buf_in_valid;
  logic [`IRC_WORD_W-1:0]   buf_in_data;
  logic [`IRC_WORD_W-1:0]   buf_out_data;

  assign timer_now = {timer_seconds_field, timer_cycle_field};
  assign req       = avs_read || avs_write;
  assign take      = req && !avs_waitrequest;
  assign match_hit = irc_decode(avs_address, `IRC_MATCH_BASE);
  assign ctrl_hit  = irc_decode(avs_address, `IRC_CTRL_BASE);

  // One wait state: low for exactly one cycle per request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  // Readback of the addressed register
  always_comb begin
    match_word = match_q[match_hit[1:0]] & `IRC_MATCH_WMASK;
    ctrl_word  = 32'h0000_0000;
    ctrl_word[`IRC_CTRL_CYCLE_EN] = cycle_en_q[ctrl_hit[1:0]];
    ctrl_word[`IRC_CTRL_RUN]      = run_q[ctrl_hit[1:0]];
    ctrl_word[`IRC_CTRL_ACTIVE]   = active[ctrl_hit[1:0]];
    ctrl_word[`IRC_CTRL_WAITING]  = waiting[ctrl_hit[1:0]];
    if (match_hit[2]) begin
      rd_d = match_word;
    end else if (ctrl_hit[2]) begin
      rd_d = ctrl_word;
    end else begin
      rd_d = 32'h0000_0000; // Unmapped reads as zero
    end
  end

  // Read data captured while the wait state is shown
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_d;
    end
  end

  // Per-context registers, sequencer and filter
  genvar g;
  generate
    for (g = 0; g < NCTX; g++) begin : g_ctx
      logic [31:0] ctrl_new;
      logic        timer_hit;
      logic        sync_wait;

      assign ctrl_new  = irc_merge({2'h0, cycle_en_q[g], 13'h0000, run_q[g], 15'h0000},
                                   avs_writedata, avs_byteenable, 32'hFFFF_FFFF);
      assign timer_hit = (timer_now == match_q[g][`IRC_START_HI:`IRC_START_LO]);
      assign sync_wait = (descriptor_wait_field[2*g+1 -: 2] == `IRC_WAIT_SYNC);
      assign active[g]  = (state_q[g] != irc_pkg::IRC_IDLE);
      assign waiting[g] = (state_q[g] == irc_pkg::IRC_WAIT_CYCLE);

      // Filter register write, reserved bits never stored
      always_ff @(posedge core_clk) begin
        if (reset) begin
          match_q[g] <= `IRC_MATCH_RESET;
        end else if (take && avs_write && match_hit[2] && (match_hit[1:0] == 2'(g))) begin
          match_q[g] <= irc_merge(match_q[g], avs_writedata, avs_byteenable,
                                  `IRC_MATCH_WMASK);
        end
      end

      // Control write; hardware never alters run except by reset
      always_ff @(posedge core_clk) begin
        if (reset) begin
          run_q[g]      <= 1'b0;
          cycle_en_q[g] <= 1'b0;
        end else if (take && avs_write && ctrl_hit[2] && (ctrl_hit[1:0] == 2'(g))) begin
          run_q[g]      <= ctrl_new[`IRC_CTRL_RUN];
          cycle_en_q[g] <= ctrl_new[`IRC_CTRL_CYCLE_EN];
        end
      end

      // Start sequencing: idle, waiting for start cycle, receiving
      always_ff @(posedge core_clk) begin
        if (reset) begin
          state_q[g] <= irc_pkg::IRC_IDLE;
        end else begin
          case (state_q[g])
            irc_pkg::IRC_IDLE: begin
              if (run_q[g]) begin
                if (cycle_en_q[g]) begin
                  state_q[g] <= irc_pkg::IRC_WAIT_CYCLE;
                end else begin
                  state_q[g] <= irc_pkg::IRC_RECEIVE;
                end
              end
            end
            irc_pkg::IRC_WAIT_CYCLE: begin
              if (!run_q[g]) begin
                state_q[g] <= irc_pkg::IRC_IDLE;
              end else if (timer_hit) begin
                state_q[g] <= irc_pkg::IRC_RECEIVE;
              end
            end
            irc_pkg::IRC_RECEIVE: begin
              if (!run_q[g]) begin
                state_q[g] <= irc_pkg::IRC_IDLE;
              end
            end
            default: begin
              state_q[g] <= irc_pkg::IRC_IDLE;
            end
          endcase
        end
      end

      // Acceptance decision for this context
      irc_filter u_filter (
        .accept_tags           (match_q[g][`IRC_TAG_HI:`IRC_TAG_LO]),
        .one_tag_sync_restrict (match_q[g][`IRC_SYNC_RESTRICT]),
        .accepted_channel      (match_q[g][`IRC_CHAN_HI:`IRC_CHAN_LO]),
        .sync_value            (match_q[g][`IRC_SYNC_HI:`IRC_SYNC_LO]),
        .sync_wait             (sync_wait),
        .receiving             (state_q[g] == irc_pkg::IRC_RECEIVE),
        .pkt_channel           (pkt_channel),
        .pkt_tag               (pkt_tag),
        .pkt_sync              (pkt_sync),
        .accept                (accept[g])
      );
    end
  endgenerate

  // Rejected packets are consumed and dropped; accepted ones are buffered
  assign buf_in_valid = pkt_valid && (|accept);
  assign buf_in_data  = {accept, pkt_channel, pkt_tag, pkt_sync};

  // Two-entry buffer keeps words during a receiver stall
  irc_skid #(
    .WIDTH (`IRC_WORD_W)
  ) u_skid (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (buf_in_valid),
    .in_ready  (pkt_ready),
    .in_data   (buf_in_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out_data)
  );

  // Fields of the buffered word
  assign out_context_mask = buf_out_data[15:12];
  assign out_channel      = buf_out_data[11:6];
  assign out_tag          = buf_out_data[5:4];
  assign out_sync         = buf_out_data[3:0];

endmodule

// ==== verif/irc_match_props.sv ====
// Purpose: Port-level checks of the receive filter
// Assumes: Sees only the irc_match ports
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module irc_match_props (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pkt_valid,
  input wire logic        pkt_ready,
  input wire logic [5:0]  pkt_channel,
  input wire logic [1:0]  pkt_tag,
  input wire logic [3:0]  pkt_sync,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [3:0]  out_context_mask,
  input wire logic [5:0]  out_channel,
  input wire logic [1:0]  out_tag,
  input wire logic [3:0]  out_sync
);
  // One clock domain for every check
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Bus answer timing and reserved bits in read data
  chk_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  chk_bus_no_spurious: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("answer without request");
  chk_rsvd_zero: assert property (avs_read && !avs_waitrequest |->
    !avs_readdata[27] && !avs_readdata[7]) else $error("reserved bit read one");
  // Delivered headers
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid
    && $stable({out_context_mask, out_channel, out_tag, out_sync})) else $error("out moved");
  chk_mask_set: assert property (out_valid |-> out_context_mask != 4'h0)
    else $error("delivery with empty mask");
  chk_new_fields: assert property ($rose(out_valid) |-> $past(pkt_valid && pkt_ready)
    && {out_channel, out_tag, out_sync} == $past({pkt_channel, pkt_tag, pkt_sync}))
    else $error("delivered header differs");
  chk_ready_back: assert property (!pkt_ready && out_valid && out_ready |-> ##[1:2] pkt_ready)
    else $error("buffer stays full");
  chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !out_valid && !pkt_ready
    && avs_waitrequest) else $error("outputs busy after reset");
endmodule

bind irc_match irc_match_props u_props (.core_clk, .reset, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .pkt_valid, .pkt_ready, .pkt_channel, .pkt_tag,
  .pkt_sync, .out_valid, .out_ready, .out_context_mask, .out_channel, .out_tag, .out_sync);

// ==== verif/irc_link_model.sv ====
// Purpose: Link side that offers isochronous headers
// Assumes: Headers queued by the bench through send
// Notes:   Idle fields toggle so stale values never look valid
`timescale 1ns/1ps
module irc_link_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       pkt_ready,
  output logic            pkt_valid,
  output logic [5:0]      pkt_channel,
  output logic [1:0]      pkt_tag,
  output logic [3:0]      pkt_sync
);
  logic [11:0] q [$];
  // Queue one header
  task automatic send(input logic [11:0] h);
    q.push_back(h);
  endtask
  // All headers taken
  function automatic logic idle();
    return q.size() == 0 && !pkt_valid;
  endfunction
  // Offer with random gaps, hold until taken
  always @(posedge core_clk) begin
    if (reset) begin
      pkt_valid <= 1'b0;
      {pkt_channel, pkt_tag, pkt_sync} <= 12'h000;
    end else if (!pkt_valid || pkt_ready) begin
      if (q.size() != 0 && $urandom_range(3) != 0) begin
        {pkt_channel, pkt_tag, pkt_sync} <= q.pop_front();
        pkt_valid <= 1'b1;
      end else begin
        pkt_valid <= 1'b0;
        {pkt_channel, pkt_tag, pkt_sync} <= ~{pkt_channel, pkt_tag, pkt_sync};
      end
    end
  end
endmodule

// ==== verif/tb_irc_match.sv ====
// Purpose: Self-checking bench of the receive filter
// Assumes: Link model offers headers; bench drives bus, timer and consumer
// Notes:   Expected deliveries queued at send time, checked in order
`timescale 1ns/1ps
`include "irc_consts.svh"
module tb_irc_match;
  logic        core_clk, reset, avs_read, avs_write, pkt_valid, pkt_ready;
  logic        out_valid, out_ready, avs_waitrequest, stall;
  logic [15:0] avs_address;
  logic [3:0]  avs_byteenable, out_context_mask, rcv;
  logic [31:0] avs_writedata, avs_readdata, rd, v;
  logic [1:0]  timer_seconds_field, pkt_tag, out_tag;
  logic [12:0] timer_cycle_field;
  logic [7:0]  descriptor_wait_field;
  logic [5:0]  pkt_channel, out_channel;
  logic [3:0]  pkt_sync, out_sync;
  logic [31:0] cfg [4];
  logic [15:0] exp_q [$];
  int          n_errors, compares;

  irc_match dut (.core_clk, .reset, .avs_address, .avs_byteenable, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .timer_seconds_field,
    .timer_cycle_field, .descriptor_wait_field, .pkt_valid, .pkt_ready, .pkt_channel,
    .pkt_tag, .pkt_sync, .out_valid, .out_ready, .out_context_mask, .out_channel,
    .out_tag, .out_sync);
  irc_link_model u_link (.core_clk, .reset, .pkt_ready, .pkt_valid, .pkt_channel,
    .pkt_tag, .pkt_sync);

  function automatic logic [15:0] fa(input int n);
    return 16'(`IRC_MATCH_BASE + `IRC_CTX_STRIDE * n);
  endfunction
  function automatic logic [15:0] ca(input int n);
    return 16'(`IRC_CTRL_BASE + `IRC_CTX_STRIDE * n);
  endfunction
  // Contexts that should take a header
  function automatic logic [3:0] want(input logic [11:0] h);
    logic [3:0] m;
    for (int n = 0; n < 4; n++) begin
      m[n] = rcv[n] && cfg[n][5:0] == h[11:6] && cfg[n][28 + h[5:4]]
        && !(cfg[n][6] && h[5:4] == 2'h1 && h[3:2] != 2'h0)
        && !(descriptor_wait_field[2*n+:2] == 2'h3 && h[3:0] != cfg[n][11:8]);
    end
    return m;
  endfunction
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Request stands until the rising edge that sees waitrequest low
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0000_0000);
    check(what, e, rd);
  endtask
  task automatic pkt(input logic [11:0] h);
    logic [3:0] m;
    m = want(h);
    if (m != 4'h0) exp_q.push_back({m, h});
    u_link.send(h);
  endtask
  task automatic drain();
    while (!u_link.idle() || exp_q.size() != 0) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic stop_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end
  // Consumer with random stalls
  always @(posedge core_clk) out_ready <= !stall && $urandom_range(2) != 0;
  // Delivered headers against the oldest note
  always @(posedge core_clk) begin
    if (!reset && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check("stray", 32'h0, 32'hFFFF_FFFF);
      else check("deliver", 32'(exp_q.pop_front()),
        32'({out_context_mask, out_channel, out_tag, out_sync}));
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h13B9DAA9));
    {reset, stall, rcv} = 6'h20;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {timer_seconds_field, timer_cycle_field, descriptor_wait_field} = '0;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      rd_chk(fa(n), `IRC_MATCH_RESET, "reset value");
      bus(1'b1, fa(n), 32'hFFFF_FFFF);
      rd_chk(fa(n), `IRC_MATCH_WMASK, "writable bits");
    end
    rd_chk(16'h4110, 32'h0000_0000, "unmapped");
    for (int r = 0; r < 6; r++) begin
      for (int n = 0; n < 4; n++) begin
        v = $urandom & 32'hFFFF_FFC3;
        cfg[n] = v & `IRC_MATCH_WMASK;
        bus(1'b1, fa(n), v);
        bus(1'b1, ca(n), 32'h0000_8000);
      end
      for (int n = 0; n < 4; n++) rd_chk(fa(n), cfg[n], "own register");
      descriptor_wait_field <= 8'($urandom);
      {timer_seconds_field, timer_cycle_field} <= 15'($urandom);
      rcv = 4'hF;
      repeat (3) @(posedge core_clk);
      repeat (40) pkt({4'h0, 8'($urandom)});
      drain();
    end
    // Stalled consumer fills the buffer
    stall <= 1'b1;
    descriptor_wait_field <= 8'h00;
    cfg[0] = 32'hF000_0001;
    bus(1'b1, fa(0), cfg[0]);
    for (int k = 0; k < 4; k++) pkt({6'h01, 6'(k * 5)});
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    check("full ready", 32'h0, 32'(pkt_ready));
    check("full valid", 32'h1, 32'(out_valid));
    @(posedge core_clk);
    stall <= 1'b0;
    drain();
    rd_chk(ca(0), 32'h0000_8400, "run kept");
    // Stopped contexts take nothing
    for (int n = 0; n < 4; n++) bus(1'b1, ca(n), 32'h0000_0000);
    rcv = 4'h0;
    pkt(12'h040);
    drain();
    // Start on a chosen cycle
    cfg[3] = 32'hF000_0002 | (32'h5A3C << 12);
    bus(1'b1, fa(3), cfg[3]);
    {timer_seconds_field, timer_cycle_field} <= 15'h5A3D;
    bus(1'b1, ca(3), 32'h2000_8000);
    rd_chk(ca(3), 32'h2000_8600, "waiting");
    pkt(12'h080);
    drain();
    {timer_seconds_field, timer_cycle_field} <= 15'h5A3C;
    repeat (2) @(posedge core_clk);
    {timer_seconds_field, timer_cycle_field} <= 15'h5A3D;
    rcv = 4'h8;
    rd_chk(ca(3), 32'h2000_8400, "started");
    pkt(12'h080);
    drain();
    check("left over", 32'h0, 32'(exp_q.size()));
    stop_test();
  end
endmodule
